// ---- core/axf_core.sv ----
// Purpose: excitation, monitor selection and result framing of the adc
// Assumes: avalon-mm slave, one waitrequest cycle per access
// Notes: result words are framed into a byte stream for the serial slave
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "axf_params.svh"

module axf_core import axf_pkg::*; #(
  parameter int SETTLE_CYC = `AXF_SETTLE_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] conv_data,
  input wire logic out_ready,
  output logic [7:0] out_byte,
  output logic out_valid,
  output axf_exc_t exc,
  output axf_ana_t ana,
  output logic conv_run
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ b[i]) begin
        r = {r[14:0], 1'b0} ^ `AXF_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_byte

  function automatic logic is_monitor(input logic [3:0] s);
    return s == `AXF_SEL_AVDD || s == `AXF_SEL_EXTREF;
  endfunction : is_monitor

  ////////////////////////////////////////////////////////////////////////////
  // state
  axf_cfg_t cfg_q, cfg_d;
  axf_state_t st_q, st_d;
  logic sleep_pend_q, sleep_pend_d;
  logic [7:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d;
  logic [31:0] settle_q, settle_d;
  logic [2:0] cur_q, cur_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [7:0] fr_q [0:5];
  logic [7:0] fr_d [0:5];
  logic [2:0] fr_len_q, fr_len_d, fr_idx_q, fr_idx_d;
  logic fr_busy_q, fr_busy_d;
  axf_exc_t exc_d;
  axf_ana_t ana_d;
  logic run_d;

  logic req;
  logic wr_cfg, wr_cmd, rd_out;
  logic cmd_start, cmd_sleep, cmd_reset, cmd_done;
  axf_cfg_t new_cfg;

  assign req = (avs_read | avs_write) & ~ack_q;
  assign wr_cfg = req & avs_write & (avs_address == `AXF_OFS_CFG);
  assign wr_cmd = req & avs_write & (avs_address == `AXF_OFS_CMD);
  assign rd_out = req & avs_read & (avs_address == `AXF_OFS_OUT);
  assign cmd_start = wr_cmd & avs_writedata[`AXF_CMD_START];
  assign cmd_sleep = wr_cmd & avs_writedata[`AXF_CMD_SLEEP];
  assign cmd_reset = wr_cmd & avs_writedata[`AXF_CMD_RESET];
  assign cmd_done = wr_cmd & avs_writedata[`AXF_CMD_DONE];
  assign new_cfg = axf_cfg_t'(avs_writedata[23:0]);

  ////////////////////////////////////////////////////////////////////////////
  // registers, conversion sequence and counter
  always_comb begin
    cfg_d = cfg_q;
    st_d = st_q;
    sleep_pend_d = sleep_pend_q;
    cnt_d = cnt_q;
    res_d = res_q;
    cur_d = cur_q;
    settle_d = settle_q;
    ack_d = req;
    rdata_d = 32'h00000000;
    if (wr_cfg) begin
      cfg_d = new_cfg;
      if (!cfg_q.data_counter_enable && new_cfg.data_counter_enable) begin
        cnt_d = 8'h00;
      end
      if (st_q == AXF_CONV) begin
        st_d = AXF_CONV; // a config write leaves the conversion running
      end
    end
    if (cmd_start) begin
      st_d = AXF_CONV;
      sleep_pend_d = 1'b0;
    end
    if (cmd_sleep) begin
      if (st_q == AXF_CONV) begin
        sleep_pend_d = 1'b1;
      end else begin
        st_d = AXF_SLEEP;
      end
    end
    if (cmd_done && st_q == AXF_CONV && !cmd_start) begin
      cnt_d = cnt_q + 8'h01;
      if (cfg_q.ts) begin
        res_d = {conv_data[15:2], 2'b00};
      end else begin
        res_d = conv_data;
      end
      if (sleep_pend_q || cmd_sleep) begin
        st_d = AXF_SLEEP;
        sleep_pend_d = 1'b0;
      end else if (!cfg_q.cm) begin
        st_d = AXF_IDLE;
      end
    end
    // settle timer restarts whenever the programmed current changes
    if (cfg_d.excitation_current_select != cur_q) begin
      cur_d = cfg_d.excitation_current_select;
      settle_d = 32'(SETTLE_CYC);
    end else if (settle_q != 32'h00000000) begin
      settle_d = settle_q - 32'h00000001;
    end
    if (req && avs_read) begin
      case (avs_address)
        `AXF_OFS_CFG: rdata_d = {8'h00, cfg_q};
        `AXF_OFS_STAT: rdata_d = {12'h000, sleep_pend_q, st_q,
                                  settle_q == 32'h00000000, cnt_q, res_q[7:0]};
        `AXF_OFS_OUT: rdata_d = {8'h00, cnt_q, res_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (cmd_reset) begin
      cfg_d = `AXF_CFG_RST;
      st_d = AXF_IDLE;
      sleep_pend_d = 1'b0;
      cnt_d = 8'h00;
      res_d = 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_q <= `AXF_CFG_RST;
      st_q <= AXF_IDLE;
      sleep_pend_q <= 1'b0;
      cnt_q <= 8'h00;
      res_q <= 16'h0000;
      cur_q <= 3'h0;
      settle_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      st_q <= st_d;
      sleep_pend_q <= sleep_pend_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      cur_q <= cur_d;
      settle_q <= settle_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result framing: counter, data, then inverted copy or crc
  always_comb begin
    logic [15:0] c;
    logic [2:0] n;
    c = `AXF_CRC_SEED;
    n = 3'd0;
    fr_d = fr_q;
    fr_len_d = fr_len_q;
    fr_idx_d = fr_idx_q;
    fr_busy_d = fr_busy_q;
    if (fr_busy_q && out_ready) begin
      if (fr_idx_q == fr_len_q - 3'd1) begin
        fr_busy_d = 1'b0;
      end
      fr_idx_d = fr_idx_q + 3'd1;
    end
    if (rd_out && !fr_busy_q) begin
      if (cfg_q.data_counter_enable) begin
        fr_d[0] = cnt_q;
        n = 3'd1;
      end
      fr_d[n] = res_q[15:8];
      fr_d[n + 3'd1] = res_q[7:0];
      case (cfg_q.integ)
        AXF_INT_INV: begin
          for (int i = 0; i < 3; i++) begin
            fr_d[3'(i) + n + 3'd2] = ~fr_d[i];
          end
          fr_len_d = 3'd2 * (n + 3'd2);
        end
        AXF_INT_CRC: begin
          for (int i = 0; i < 3; i++) begin
            if (3'(i) < n + 3'd2) begin
              c = crc_byte(c, fr_d[i]);
            end
          end
          fr_d[n + 3'd2] = c[15:8];
          fr_d[n + 3'd3] = c[7:0];
          fr_len_d = n + 3'd4;
        end
        default: fr_len_d = n + 3'd2;
      endcase
      fr_idx_d = 3'd0;
      fr_busy_d = 1'b1;
    end
    if (cmd_reset) begin
      fr_busy_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        fr_q[i] <= 8'h00;
      end
      fr_len_q <= 3'd0;
      fr_idx_q <= 3'd0;
      fr_busy_q <= 1'b0;
    end else begin
      fr_q <= fr_d;
      fr_len_q <= fr_len_d;
      fr_idx_q <= fr_idx_d;
      fr_busy_q <= fr_busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog control outputs
  always_comb begin
    logic src_on;
    src_on = cfg_q.excitation_current_select != 3'h0 && st_q != AXF_SLEEP;
    exc_d.bias_on = src_on;
    exc_d.current = cfg_q.excitation_current_select;
    exc_d.valid = src_on && settle_q == 32'h00000000;
    exc_d.route1 = src_on ? cfg_q.first_source_route : 3'h0;
    exc_d.route2 = src_on ? cfg_q.second_source_route : 3'h0;
    ana_d.temp_mode = cfg_q.ts;
    ana_d.input_select = cfg_q.input_select;
    ana_d.burn_p = cfg_q.burnout_source_enable && !cfg_q.ts;
    ana_d.burn_n = cfg_q.burnout_source_enable && !cfg_q.ts;
    ana_d.pga_bypass = is_monitor(cfg_q.input_select) || cfg_q.ts;
    ana_d.gain = ana_d.pga_bypass ? 3'h0 : cfg_q.gain;
    ana_d.int_ref = ana_d.pga_bypass;
    ana_d.ref_sel = cfg_q.ref_sel;
    run_d = st_q == AXF_CONV;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      exc <= '0;
      ana <= '0;
      conv_run <= 1'b0;
      out_byte <= 8'h00;
      out_valid <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      exc <= exc_d;
      ana <= ana_d;
      conv_run <= run_d;
      out_byte <= fr_busy_d ? fr_d[fr_idx_d] : 8'h00;
      out_valid <= fr_busy_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= ~req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_cnt_wrap: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_done && st_q == AXF_CONV && !cmd_start && !cmd_reset && !wr_cfg
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not advance");
  a_gain_forced: assert property (@(posedge clock)
    disable iff (!resetn)
    is_monitor(cfg_q.input_select) |=> ana.gain == 3'h0 && ana.int_ref)
    else $error("monitor gain not forced");
  a_sleep_off: assert property (@(posedge clock)
    disable iff (!resetn)
    st_q == AXF_SLEEP |=> !exc.bias_on)
    else $error("sources on in sleep");
  a_sleep_wait: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_sleep && st_q == AXF_CONV && !cmd_reset && !cmd_done
    |=> st_q == AXF_CONV)
    else $error("sleep cut conversion");
  a_cnt_reset: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_reset |=> cnt_q == 8'h00 && cfg_q == `AXF_CFG_RST)
    else $error("reset command ignored");
  a_ts_lsb: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_done && st_q == AXF_CONV && cfg_q.ts && !cmd_start && !cmd_reset
    |=> res_q[1:0] == 2'b00)
    else $error("temperature low bits set");
  a_route_off: assert property (@(posedge clock)
    disable iff (!resetn)
    cfg_q.excitation_current_select == 3'h0 |=> exc.route1 == 3'h0
    && exc.route2 == 3'h0)
    else $error("source routed while off");
  a_settle_valid: assert property (@(posedge clock)
    disable iff (!resetn)
    cur_q != cfg_d.excitation_current_select |=> !exc_d.valid)
    else $error("current valid too early");
  a_bias_sel: assert property (@(posedge clock)
    disable iff (!resetn)
    cfg_q.excitation_current_select != 3'h0 && st_q != AXF_SLEEP
    |=> exc.bias_on)
    else $error("bias not enabled");
  a_burn_temp: assert property (@(posedge clock)
    disable iff (!resetn)
    cfg_q.ts |=> !ana.burn_p && !ana.burn_n && ana.int_ref)
    else $error("temperature mode not isolated");
  a_ts_gain: assert property (@(posedge clock)
    disable iff (!resetn)
    cfg_q.ts |=> ana.pga_bypass && ana.gain == 3'h0 && ana.temp_mode)
    else $error("temperature mode gain not forced");
  a_frame_cnt: assert property (@(posedge clock)
    disable iff (!resetn)
    rd_out && !fr_busy_q && cfg_q.data_counter_enable && !cmd_reset
    |=> out_valid && out_byte == $past(cnt_q))
    else $error("counter word not first");
  a_single_idle: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_done && st_q == AXF_CONV && !cfg_q.cm && !sleep_pend_q && !cmd_sleep
    && !cmd_start |=> st_q == AXF_IDLE)
    else $error("single-shot did not stop");
  a_start_run: assert property (@(posedge clock)
    disable iff (!resetn)
    cmd_start && !cmd_sleep && !cmd_reset |=> st_q == AXF_CONV)
    else $error("start command ignored");
  c_crc_frame: cover property (@(posedge clock)
    rd_out && cfg_q.integ == AXF_INT_CRC);
  c_inv_frame: cover property (@(posedge clock)
    rd_out && cfg_q.integ == AXF_INT_INV);
  c_wrap: cover property (@(posedge clock) cnt_q == 8'hFF ##1 cnt_q == 8'h00);
  c_ts_conv: cover property (@(posedge clock) cmd_done && cfg_q.ts);
  c_sleep: cover property (@(posedge clock) st_q == AXF_SLEEP);

endmodule : axf_core

// ---- pkg/axf_params.svh ----
// Purpose: constants for the auxiliary-function and output-format block
// Assumes: 40 MHz clock, 32-bit Avalon-MM register bus, byte addressing
// Notes: byte offsets of the register words
`ifndef AXF_PARAMS_SVH
`define AXF_PARAMS_SVH

`define AXF_OFS_CFG 4'h0
`define AXF_OFS_CMD 4'h4
`define AXF_OFS_STAT 4'h8
`define AXF_OFS_OUT 4'hC

// configuration word field positions
`define AXF_CUR_LSB 0
`define AXF_R1_LSB 3
`define AXF_R2_LSB 6
`define AXF_BURN_BIT 9
`define AXF_SEL_LSB 10
`define AXF_GAIN_LSB 14
`define AXF_REF_LSB 17
`define AXF_TS_BIT 19
`define AXF_DATA_COUNTER_ENABLE_BIT 20
`define AXF_INTEG_LSB 21
`define AXF_CM_BIT 23

// command word: bit 0 start, bit 1 sleep, bit 2 reset, bit 3 done
`define AXF_CMD_START 0
`define AXF_CMD_SLEEP 1
`define AXF_CMD_RESET 2
`define AXF_CMD_DONE 3

`define AXF_CFG_RST 24'h000000
`define AXF_CRC_SEED 16'hFFFF
`define AXF_CRC_POLY 16'h1021

`define AXF_SEL_AVDD 4'hD
`define AXF_SEL_EXTREF 4'hC
`define AXF_SEL_SHORT 4'hE

`define AXF_SETTLE_US 200
`define AXF_CLK_MHZ 40
`define AXF_SETTLE_CYC (`AXF_SETTLE_US * `AXF_CLK_MHZ)

`endif

// ---- pkg/axf_pkg.sv ----
// Purpose: types of the auxiliary-function and output-format block
// Assumes: constants come from axf_params.svh
// Notes: none
package axf_pkg;

  typedef enum logic [1:0] {
    AXF_IDLE = 2'b00,
    AXF_CONV = 2'b01,
    AXF_SLEEP = 2'b10
  } axf_state_t;

  typedef enum logic [1:0] {
    AXF_INT_NONE = 2'b00,
    AXF_INT_INV = 2'b01,
    AXF_INT_CRC = 2'b10,
    AXF_INT_RSV = 2'b11
  } axf_integ_t;

  typedef struct packed {
    logic cm;
    axf_integ_t integ;
    logic data_counter_enable;
    logic ts;
    logic [1:0] ref_sel;
    logic [2:0] gain;
    logic [3:0] input_select;
    logic burnout_source_enable;
    logic [2:0] second_source_route;
    logic [2:0] first_source_route;
    logic [2:0] excitation_current_select;
  } axf_cfg_t;

  typedef struct packed {
    logic bias_on;
    logic valid;
    logic [2:0] current;
    logic [2:0] route1;
    logic [2:0] route2;
  } axf_exc_t;

  typedef struct packed {
    logic [2:0] gain;
    logic pga_bypass;
    logic int_ref;
    logic [1:0] ref_sel;
    logic [3:0] input_select;
    logic burn_p;
    logic burn_n;
    logic temp_mode;
  } axf_ana_t;

endpackage : axf_pkg

// ---- verification/axf_sink.sv ----
// Purpose: byte stream sink standing at the result port
// Assumes: stream handshake is valid and ready on the rising edge
// Notes: stalls one cycle in four; bytes kept in arrival order
`timescale 1ns/10ps
module axf_sink (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  output logic out_ready
);
  logic [7:0] got [0:63];
  int n = 0;
  logic [1:0] ph_q = 2'h0;
  logic ready_q = 1'b0;
  assign out_ready = ready_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ph_q <= 2'h0;
      ready_q <= 1'b0;
      n <= 0;
    end else begin
      ph_q <= ph_q + 2'h1;
      ready_q <= (ph_q != 2'h3);
      if (out_valid && ready_q) begin
        got[n[5:0]] <= out_byte;
        n <= n + 1;
      end
    end
  end
endmodule : axf_sink

// ---- verification/axf_core_tb.sv ----
// Purpose: self-checking bench of the aux-function and framing core
// Assumes: one waitrequest cycle, settle count shortened to 8
// Notes: result bytes collected by the sink model
`timescale 1ns/10ps
`include "axf_params.svh"
module adc_aux_sources_and_output_format_tb import axf_pkg::*; ();
  localparam int P = 8;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, out_valid, out_ready, conv_run;
  logic [15:0] conv_data = 16'h0;
  logic [7:0] out_byte;
  axf_exc_t exc;
  axf_ana_t ana;
  axf_cfg_t c;
  int mismatches = 0, checks = 0;

  axf_core #(.SETTLE_CYC(P)) axf_core_inst (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_data(conv_data),
    .out_ready(out_ready), .out_byte(out_byte), .out_valid(out_valid),
    .exc(exc), .ana(ana), .conv_run(conv_run));
  axf_sink axf_sink_inst (.clock(clock), .resetn(resetn), .out_byte(out_byte),
    .out_valid(out_valid), .out_ready(out_ready));

  initial begin
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
      n++;
      if (n > 20) begin
        mismatches++;
        close_out;
      end
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : acc

  task cfg_w;
    acc(1'b1, `AXF_OFS_CFG, {8'h00, c});
    repeat (2) @(posedge clock);
  endtask : cfg_w

  task cmd(input int b);
    acc(1'b1, `AXF_OFS_CMD, 32'h1 << b);
  endtask : cmd

  task conv(input logic [15:0] d);
    cmd(`AXF_CMD_START);
    conv_data <= d;
    cmd(`AXF_CMD_DONE);
    repeat (2) @(posedge clock);
  endtask : conv

  task frame(input int k, input logic [47:0] e);
    int b, n;
    b = axf_sink_inst.n;
    n = 0;
    acc(1'b0, `AXF_OFS_OUT, 32'h0);
    while (axf_sink_inst.n < b + k) begin
      @(posedge clock);
      n++;
      if (n > 100) begin
        mismatches++;
        close_out;
      end
    end
    for (int i = 0; i < k; i++) begin
      chk("byte", axf_sink_inst.got[b + i], e[8*(k-1-i) +: 8]);
    end
  endtask : frame

  function automatic logic [15:0] crc(input logic [23:0] d, input int nb);
    logic [15:0] r;
    r = `AXF_CRC_SEED;
    for (int i = 8 * nb - 1; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `AXF_CRC_POLY : 16'h0);
    end
    return r;
  endfunction : crc
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    acc(1'b0, `AXF_OFS_CFG, 32'h0);
    chk("cfg", q, 32'h0);
    acc(1'b1, 4'h2, 32'hFFFF);
    acc(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    acc(1'b0, `AXF_OFS_STAT, 32'h0);
    chk("count", q[15:8], 8'h00);
    chk("exc", exc, 11'h000);
  endtask : t_reset

  task t_exc;
    c = '0;
    for (int i = 0; i < 8; i++) begin
      c.excitation_current_select = i[2:0];
      cfg_w;
      chk("cur", exc.current, i);
      chk("bias", exc.bias_on, i != 0);
    end
    c.excitation_current_select = 3'h0;
    cfg_w;
    c.excitation_current_select = 3'h3;
    cfg_w;
    chk("valid", exc.valid, 1'b0);
    repeat (P + 2) @(posedge clock);
    chk("valid", exc.valid, 1'b1);
    c.first_source_route = 3'h5;
    c.second_source_route = 3'h5;
    cfg_w;
    chk("route1", exc.route1, 3'h5);
    chk("route2", exc.route2, 3'h5);
  endtask : t_exc

  task t_mon;
    c = '0;
    c.gain = 3'h4;
    c.ref_sel = 2'h2;
    c.input_select = `AXF_SEL_AVDD;
    cfg_w;
    chk("bypass", ana.pga_bypass, 1'b1);
    chk("gain", ana.gain, 3'h0);
    chk("intref", ana.int_ref, 1'b1);
    c.input_select = `AXF_SEL_EXTREF;
    cfg_w;
    chk("intref", ana.int_ref, 1'b1);
    c.input_select = `AXF_SEL_SHORT;
    cfg_w;
    chk("short", ana.input_select, `AXF_SEL_SHORT);
    c.input_select = 4'h0;
    c.burnout_source_enable = 1'b1;
    cfg_w;
    chk("bypass", ana.pga_bypass, 1'b0);
    chk("burn", {ana.burn_p, ana.burn_n}, 2'h3);
    c.ts = 1'b1;
    cfg_w;
    chk("temp", {ana.temp_mode, ana.int_ref}, 2'h3);
    chk("burn", {ana.burn_p, ana.burn_n}, 2'h0);
    chk("gain", ana.gain, 3'h0);
    c.burnout_source_enable = 1'b0;
    cfg_w;
    conv(16'h3CE3);
    frame(2, 48'h3CE0);
  endtask : t_mon

  task t_conv;
    c = '0;
    c.data_counter_enable = 1'b1;
    c.integ = AXF_INT_INV;
    cfg_w;
    conv(16'h1234);
    frame(6, 48'h011234FEEDCB);
    chk("out", q[23:0], 24'h011234);
    c.integ = AXF_INT_CRC;
    cfg_w;
    conv(16'hA55A);
    frame(5, {8'h02, 16'hA55A, crc(24'h02A55A, 3)});
    c.data_counter_enable = 1'b0;
    cfg_w;
    conv(16'h0);
    c.data_counter_enable = 1'b1;
    cfg_w;
    acc(1'b0, `AXF_OFS_STAT, 32'h0);
    chk("clear", q[15:8], 8'h00);
    for (int i = 0; i < 255; i++) conv(i[15:0]);
    acc(1'b0, `AXF_OFS_STAT, 32'h0);
    chk("top", q[15:8], 8'hFF);
    conv(16'h0);
    acc(1'b0, `AXF_OFS_STAT, 32'h0);
    chk("wrap", q[15:8], 8'h00);
  endtask : t_conv

  task t_sleep;
    c = '0;
    c.excitation_current_select = 3'h3;
    cfg_w;
    conv(16'h0);
    chk("run", conv_run, 1'b0);
    chk("bias", exc.bias_on, 1'b1);
    c.cm = 1'b1;
    cfg_w;
    conv(16'h0);
    chk("run", conv_run, 1'b1);
    cmd(`AXF_CMD_SLEEP);
    chk("run", conv_run, 1'b1);
    cmd(`AXF_CMD_DONE);
    repeat (2) @(posedge clock);
    chk("run", conv_run, 1'b0);
    chk("bias", exc.bias_on, 1'b0);
    cmd(`AXF_CMD_RESET);
    acc(1'b0, `AXF_OFS_CFG, 32'h0);
    chk("cfg", q, 32'h0);
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset;
    t_exc;
    t_mon;
    t_conv;
    t_sleep;
    close_out;
  end
endmodule : adc_aux_sources_and_output_format_tb
